// [hdl/eesr_pkg.sv]
// Purpose: Shared constants and command codes for the extended event status block
// Assumes: One 40 MHz clock shared with the command parser and the measurement logic
// Notes: Register values are carried as plain binary; decimal text is made outside
package eesr_pkg;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int EESR_REG_W = 8;
	localparam logic [7:0] EESR_EVT_RESET = 8'h00;
	localparam logic [7:0] EESR_MASK_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Bit positions
	// ----------------------------------------------------------------
	localparam int EESR_CMP_SYNC_EST = 7;
	localparam int EESR_CMP_LEVEL_END = 6;
	localparam int EESR_CMP_FREQ_END = 5;
	localparam int EESR_CMP_AVG_END = 4;
	localparam int EESR_CMP_CAL_END = 1;
	localparam int EESR_CMP_MEAS_END = 0;
	localparam int EESR_FLT_SYNC_LOSS = 0;
	localparam logic [7:0] EESR_CMP_USED = 8'hf3;
	localparam logic [7:0] EESR_FLT_USED = 8'h01;
	localparam int EESR_STB_CMP_SUM = 2;
	localparam int EESR_STB_FLT_SUM = 3;
	localparam int EESR_OPC_BIT = 0;
	localparam logic [7:0] EESR_OPC_ANSWER = 8'h01;

	// ----------------------------------------------------------------
	// Commands from the parser
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		EESR_NOP = 4'h0,
		EESR_CLEAR_STATUS = 4'h1,
		EESR_RESET_CMD = 4'h2,
		EESR_DEVICE_CLEAR = 4'h3,
		EESR_WRITE_COMPLETION_MASK_CMD = 4'h4,
		EESR_WRITE_FAULT_MASK_CMD = 4'h5,
		EESR_READ_COMPLETION_EVENTS_QUERY = 4'h6,
		EESR_READ_FAULT_EVENTS_QUERY = 4'h7,
		EESR_READ_COMPLETION_MASK_QUERY = 4'h8,
		EESR_READ_FAULT_MASK_QUERY = 4'h9,
		EESR_SWEEP_MEASURE_CMD = 4'ha,
		EESR_SINGLE_MEASURE_CMD = 4'hb,
		EESR_OPC_CMD = 4'hc,
		EESR_OPC_QUERY = 4'hd
	} eesr_cmd_type;

endpackage : eesr_pkg

// [hdl/eesr_top.sv]
// Purpose: Completion and fault event registers, their masks, summaries and command sequencing
// Assumes: Commands arrive decoded from a parser on the same clock; events are one-cycle pulses
// Assumes: op_busy_i stays high while the previous command executes
// Notes: Notes on behaviour below; the standard event register lives outside this block
`timescale 1ns/100ps

module eesr_top (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic cmd_valid_i,
	input wire eesr_pkg::eesr_cmd_type cmd_code_i,
	input wire logic [7:0] cmd_data_i,
	output logic cmd_ready_o,
	output logic cmd_refused_o,
	output logic resp_valid_o,
	output logic [7:0] resp_data_o,
	input wire logic op_busy_i,
	input wire logic power_on_clear_flag_i,
	input wire logic [7:0] saved_completion_mask_i,
	input wire logic [7:0] saved_fault_mask_i,
	input wire logic ber_sync_established_i,
	input wire logic level_set_done_i,
	input wire logic freq_set_done_i,
	input wire logic average_done_i,
	input wire logic cal_done_i,
	input wire logic measure_done_i,
	input wire logic sync_lost_i,
	output logic measure_active_o,
	output logic opc_set_o,
	output logic completion_summary_o,
	output logic fault_summary_o,
	output logic [7:0] status_summary_bits_o
);
	import eesr_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] completion_event_status_r;
	logic [7:0] fault_event_status_r;
	logic [7:0] completion_event_enable_r;
	logic [7:0] fault_event_enable_r;
	logic power_up_r;
	logic opc_pending_r;
	logic measure_active_r;
	logic [7:0] comp_set;
	logic [7:0] fault_set;
	logic take;
	logic is_measure_cmd;
	logic clear_completion;
	logic clear_fault;
	logic write_completion_mask;
	logic write_fault_mask;
	logic opc_query_taken;
	logic opc_cmd_taken;

	// Summary of one register: any enabled event bit that is set
	function automatic logic summary_of(input logic [7:0] events, input logic [7:0] mask);
		summary_of = |(events & mask);
	endfunction : summary_of

	// Clear-status and a register's own query both empty that register
	function automatic logic clears_events(input eesr_cmd_type code, input eesr_cmd_type own_query);
		clears_events = (code == EESR_CLEAR_STATUS) || (code == own_query);
	endfunction : clears_events

	// Sweep and single measurement share one interlock
	function automatic logic is_measure(input eesr_cmd_type code);
		is_measure = (code == EESR_SWEEP_MEASURE_CMD) || (code == EESR_SINGLE_MEASURE_CMD);
	endfunction : is_measure

	// ----------------------------------------------------------------
	// Event sources
	// ----------------------------------------------------------------
	always_comb begin
		comp_set = 8'h00;
		comp_set[EESR_CMP_SYNC_EST] = ber_sync_established_i;
		comp_set[EESR_CMP_LEVEL_END] = level_set_done_i;
		comp_set[EESR_CMP_FREQ_END] = freq_set_done_i;
		comp_set[EESR_CMP_AVG_END] = average_done_i;
		comp_set[EESR_CMP_CAL_END] = cal_done_i;
		comp_set[EESR_CMP_MEAS_END] = measure_done_i;
		comp_set = comp_set & EESR_CMP_USED;
		fault_set = 8'h00;
		fault_set[EESR_FLT_SYNC_LOSS] = sync_lost_i;
		fault_set = fault_set & EESR_FLT_USED;
	end

	// ----------------------------------------------------------------
	// Command acceptance
	// ----------------------------------------------------------------
	// A pending operation-complete query or a busy instrument holds off the next command
	assign cmd_ready_o = !op_busy_i && !opc_pending_r && !power_up_r;
	assign take = cmd_valid_i && cmd_ready_o;
	assign is_measure_cmd = is_measure(cmd_code_i);
	assign measure_active_o = measure_active_r;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	// Each strobe is high only in the cycle in which its command is taken
	// Decoded once here so every register sees the same taken command
	assign clear_completion = take && clears_events(cmd_code_i, EESR_READ_COMPLETION_EVENTS_QUERY);
	assign clear_fault = take && clears_events(cmd_code_i, EESR_READ_FAULT_EVENTS_QUERY);
	assign write_completion_mask = take && (cmd_code_i == EESR_WRITE_COMPLETION_MASK_CMD);
	assign write_fault_mask = take && (cmd_code_i == EESR_WRITE_FAULT_MASK_CMD);
	assign opc_query_taken = take && (cmd_code_i == EESR_OPC_QUERY);
	assign opc_cmd_taken = take && (cmd_code_i == EESR_OPC_CMD);

	// ----------------------------------------------------------------
	// Event registers: set wins over clear; no write path exists
	// ----------------------------------------------------------------
	// An event in the same cycle as its clear survives, so no completion is lost
	// The query answer carries the value from before the clear
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			completion_event_status_r <= EESR_EVT_RESET;
		end else if (clear_completion) begin
			completion_event_status_r <= comp_set;
		end else begin
			completion_event_status_r <= completion_event_status_r | comp_set;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			fault_event_status_r <= EESR_EVT_RESET;
		end else if (clear_fault) begin
			fault_event_status_r <= fault_set;
		end else begin
			fault_event_status_r <= fault_event_status_r | fault_set;
		end
	end

	// ----------------------------------------------------------------
	// Enable masks
	// ----------------------------------------------------------------
	// Power-up cycle: masks are cleared by reset, then restored from the saved copy
	// in the first cycle after release unless the power-on clear flag is true
	// Commands are held off during that cycle so a mask write cannot be lost
	// Clear-status, the reset command and device clear leave the masks alone
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			power_up_r <= 1'b1;
		end else begin
			power_up_r <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			completion_event_enable_r <= EESR_MASK_RESET;
		end else if (power_up_r) begin
			completion_event_enable_r <= power_on_clear_flag_i ? EESR_MASK_RESET : saved_completion_mask_i;
		end else if (write_completion_mask) begin
			completion_event_enable_r <= cmd_data_i;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			fault_event_enable_r <= EESR_MASK_RESET;
		end else if (power_up_r) begin
			fault_event_enable_r <= power_on_clear_flag_i ? EESR_MASK_RESET : saved_fault_mask_i;
		end else if (write_fault_mask) begin
			fault_event_enable_r <= cmd_data_i;
		end
	end

	// ----------------------------------------------------------------
	// Measurement interlock
	// ----------------------------------------------------------------
	// A refused command is still taken, so the parser never stalls behind it;
	// a start taken while idle wins over a stray end pulse in the same cycle
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			measure_active_r <= 1'b0;
		end else if (take && is_measure_cmd && !measure_active_r) begin
			measure_active_r <= 1'b1;
		end else if (measure_done_i) begin
			measure_active_r <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_refused_o <= 1'b0;
		end else begin
			cmd_refused_o <= take && is_measure_cmd && measure_active_r;
		end
	end

	// ----------------------------------------------------------------
	// Operation complete
	// ----------------------------------------------------------------
	// The pending answer holds off new commands, so no query answer can overtake it;
	// it waits as long as op_busy_i stays high
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			opc_pending_r <= 1'b0;
		end else if (opc_query_taken) begin
			opc_pending_r <= 1'b1;
		end else if (!op_busy_i) begin
			opc_pending_r <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			opc_set_o <= 1'b0;
		end else begin
			opc_set_o <= opc_cmd_taken;
		end
	end

	// ----------------------------------------------------------------
	// Responses
	// ----------------------------------------------------------------
	// resp_data_o keeps the last answer; only resp_valid_o marks a new one
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			resp_valid_o <= 1'b0;
			resp_data_o <= 8'h00;
		end else begin
			resp_valid_o <= 1'b0;
			if (opc_pending_r && !op_busy_i) begin
				resp_valid_o <= 1'b1;
				resp_data_o <= EESR_OPC_ANSWER;
			end else if (take) begin
				case (cmd_code_i)
					EESR_READ_COMPLETION_EVENTS_QUERY: begin
						resp_valid_o <= 1'b1;
						resp_data_o <= completion_event_status_r;
					end
					EESR_READ_FAULT_EVENTS_QUERY: begin
						resp_valid_o <= 1'b1;
						resp_data_o <= fault_event_status_r;
					end
					EESR_READ_COMPLETION_MASK_QUERY: begin
						resp_valid_o <= 1'b1;
						resp_data_o <= completion_event_enable_r;
					end
					EESR_READ_FAULT_MASK_QUERY: begin
						resp_valid_o <= 1'b1;
						resp_data_o <= fault_event_enable_r;
					end
					default: begin
						resp_valid_o <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Summaries for the status byte
	// ----------------------------------------------------------------
	// Registered, so the summaries trail the event registers by one cycle
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			completion_summary_o <= 1'b0;
			fault_summary_o <= 1'b0;
		end else begin
			completion_summary_o <= summary_of(completion_event_status_r, completion_event_enable_r);
			fault_summary_o <= summary_of(fault_event_status_r, fault_event_enable_r);
		end
	end

	// Only bits 2 and 3 belong to this block; the others are filled elsewhere
	always_comb begin
		status_summary_bits_o = 8'h00;
		status_summary_bits_o[EESR_STB_CMP_SUM] = completion_summary_o;
		status_summary_bits_o[EESR_STB_FLT_SUM] = fault_summary_o;
	end

endmodule : eesr_top

// [test/eesr_ctl_model.sv]
// Purpose: Bus controller model handing decoded commands to the block
// Assumes: Requests change after a falling edge and stay until taken
// Notes: One command outstanding at a time
`timescale 1ns/100ps
module eesr_ctl_model
	import eesr_pkg::*;
(
	input wire logic clock_i,
	input wire logic cmd_ready_i,
	output logic cmd_valid_o,
	output eesr_cmd_type cmd_code_o,
	output logic [7:0] cmd_data_o
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_code_o = EESR_NOP;
		cmd_data_o = 8'h00;
	end
	task automatic issue(input eesr_cmd_type code, input logic [7:0] data);
		@(negedge clock_i);
		cmd_valid_o = 1'b1;
		cmd_code_o = code;
		cmd_data_o = data;
		while (cmd_ready_i !== 1'b1) @(negedge clock_i);
		@(posedge clock_i);
		@(negedge clock_i);
		cmd_valid_o = 1'b0;
		cmd_code_o = EESR_NOP;
		cmd_data_o = ~data;
	endtask : issue
endmodule : eesr_ctl_model

// [test/eesr_top_assertions.sv]
// Purpose: Port checks for eesr_top
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound to every eesr_top instance
`timescale 1ns/100ps
module eesr_chk
	import eesr_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic cmd_valid_i,
	input wire eesr_pkg::eesr_cmd_type cmd_code_i,
	input wire logic [7:0] cmd_data_i,
	input wire logic cmd_ready_o,
	input wire logic cmd_refused_o,
	input wire logic resp_valid_o,
	input wire logic [7:0] resp_data_o,
	input wire logic op_busy_i,
	input wire logic measure_done_i,
	input wire logic measure_active_o,
	input wire logic opc_set_o,
	input wire logic completion_summary_o,
	input wire logic fault_summary_o,
	input wire logic [7:0] status_summary_bits_o
);
	logic take;
	logic meas;
	logic opcq;
	assign take = cmd_valid_i && cmd_ready_o;
	assign meas = take && (cmd_code_i == EESR_SWEEP_MEASURE_CMD || cmd_code_i == EESR_SINGLE_MEASURE_CMD);
	assign opcq = take && cmd_code_i == EESR_OPC_QUERY;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// ----
	// Assertions
	// ----
	AST_QUERY_ANSWER: assert property (
		take && cmd_code_i inside {[EESR_READ_COMPLETION_EVENTS_QUERY:EESR_READ_FAULT_MASK_QUERY]} |=> resp_valid_o)
		else $error("query answer missing");
	AST_STATUS_MAP: assert property (
		status_summary_bits_o == {4'h0, fault_summary_o, completion_summary_o, 2'h0})
		else $error("status summary bits misplaced");
	AST_CMP_MASK_ZERO: assert property (
		take && cmd_code_i == EESR_WRITE_COMPLETION_MASK_CMD && cmd_data_i == 8'h00 |-> ##2 !completion_summary_o)
		else $error("completion summary with zero mask");
	AST_FLT_MASK_ZERO: assert property (
		take && cmd_code_i == EESR_WRITE_FAULT_MASK_CMD && cmd_data_i == 8'h00 |-> ##2 !fault_summary_o)
		else $error("fault summary with zero mask");
	AST_OPC_SET: assert property (
		take && cmd_code_i == EESR_OPC_CMD |=> opc_set_o)
		else $error("operation complete bit not set");
	AST_MEAS_REFUSE: assert property (
		meas && measure_active_o && !measure_done_i |=> cmd_refused_o && measure_active_o)
		else $error("measurement command not refused");
	AST_MEAS_START: assert property (
		meas && !measure_active_o && !measure_done_i |=> measure_active_o && !cmd_refused_o)
		else $error("measurement did not start");
	AST_BUSY_HOLD: assert property (
		op_busy_i || $past(opcq) |-> !cmd_ready_o)
		else $error("command taken while busy");
	AST_OPC_WAIT: assert property (
		opcq ##1 op_busy_i |=> !resp_valid_o)
		else $error("early operation complete answer");
	AST_OPC_ANSWER: assert property (
		opcq |-> ##[2:300] (resp_valid_o && resp_data_o == EESR_OPC_ANSWER))
		else $error("operation complete answer missing");
	C_OPCQ: cover property (opcq ##[2:20] resp_valid_o);
	C_REFUSE: cover property (cmd_refused_o);
	C_BOTH_SUM: cover property (completion_summary_o && fault_summary_o);
endmodule : eesr_chk

bind eesr_top eesr_chk u_chk (.clock_i, .rst_i, .cmd_valid_i, .cmd_code_i, .cmd_data_i, .cmd_ready_o,
	.cmd_refused_o, .resp_valid_o, .resp_data_o, .op_busy_i, .measure_done_i, .measure_active_o,
	.opc_set_o, .completion_summary_o, .fault_summary_o, .status_summary_bits_o);

// [test/testbench.sv]
// Purpose: Self-checking bench for eesr_top
// Assumes: Inputs change on the falling edge
// Notes: Events are one-cycle pulses
`timescale 1ns/100ps
module testbench;
	import eesr_pkg::*;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic flag = 1'b0;
	logic busy = 1'b0;
	logic [6:0] ev = 7'h00;
	logic cmd_valid, cmd_ready, refused, resp_valid, meas_act, opc_set;
	eesr_cmd_type cmd_code;
	logic [7:0] cmd_data, resp_data, stb;
	logic [7:0] bit_exp [1:6] = '{8'h01, 8'h02, 8'h10, 8'h20, 8'h40, 8'h80};
	eesr_cmd_type keep [3] = '{EESR_CLEAR_STATUS, EESR_RESET_CMD, EESR_DEVICE_CLEAR};
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	always #12.5 clock_i = ~clock_i;
	eesr_ctl_model ctl (.clock_i(clock_i), .cmd_ready_i(cmd_ready), .cmd_valid_o(cmd_valid),
		.cmd_code_o(cmd_code), .cmd_data_o(cmd_data));
	eesr_top dut (.clock_i(clock_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
		.cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready), .cmd_refused_o(refused), .resp_valid_o(resp_valid),
		.resp_data_o(resp_data), .op_busy_i(busy), .power_on_clear_flag_i(flag),
		.saved_completion_mask_i(8'ha5), .saved_fault_mask_i(8'h5a), .ber_sync_established_i(ev[6]),
		.level_set_done_i(ev[5]), .freq_set_done_i(ev[4]), .average_done_i(ev[3]), .cal_done_i(ev[2]),
		.measure_done_i(ev[1]), .sync_lost_i(ev[0]), .measure_active_o(meas_act), .opc_set_o(opc_set),
		.completion_summary_o(), .fault_summary_o(), .status_summary_bits_o(stb));
	// ----
	// Tasks
	// ----
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic query(input eesr_cmd_type code, input logic [7:0] exp);
		ctl.issue(code, 8'h00);
		chk("resp_valid", 8'h01, {7'h0, resp_valid});
		chk(code.name(), exp, resp_data);
	endtask : query
	task automatic pulse(input logic [6:0] v);
		@(negedge clock_i) ev = v;
		@(negedge clock_i) ev = 7'h00;
	endtask : pulse
	task automatic do_reset(input logic f);
		@(negedge clock_i) rst_i = 1'b1;
		flag = f;
		repeat (5) @(negedge clock_i);
		rst_i = 1'b0;
	endtask : do_reset
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			final_report();
		end
	end
	initial begin
		do_reset(1'b0);
		query(EESR_READ_COMPLETION_MASK_QUERY, 8'ha5);
		query(EESR_READ_FAULT_MASK_QUERY, 8'h5a);
		query(EESR_READ_COMPLETION_EVENTS_QUERY, 8'h00);
		for (int i = 1; i < 7; i++) begin
			pulse(7'h01 << i);
			query(EESR_READ_COMPLETION_EVENTS_QUERY, bit_exp[i]);
		end
		pulse(7'h7e);
		query(EESR_READ_COMPLETION_EVENTS_QUERY, 8'hf3);
		query(EESR_READ_COMPLETION_EVENTS_QUERY, 8'h00);
		pulse(7'h01);
		query(EESR_READ_FAULT_EVENTS_QUERY, 8'h01);
		query(EESR_READ_FAULT_EVENTS_QUERY, 8'h00);
		ctl.issue(EESR_WRITE_COMPLETION_MASK_CMD, 8'h02);
		ctl.issue(EESR_WRITE_FAULT_MASK_CMD, 8'h01);
		pulse(7'h10);
		@(negedge clock_i) chk("stb", 8'h00, stb);
		pulse(7'h04);
		@(negedge clock_i) chk("stb", 8'h04, stb);
		pulse(7'h01);
		@(negedge clock_i) chk("stb", 8'h0c, stb);
		for (int i = 0; i < 3; i++) begin
			ctl.issue(keep[i], 8'h00);
			@(negedge clock_i) chk("stb", 8'h00, stb);
			query(EESR_READ_COMPLETION_MASK_QUERY, 8'h02);
			query(EESR_READ_FAULT_MASK_QUERY, 8'h01);
		end
		ctl.issue(EESR_WRITE_COMPLETION_MASK_CMD, 8'hff);
		query(EESR_READ_COMPLETION_MASK_QUERY, 8'hff);
		query(EESR_READ_COMPLETION_MASK_QUERY, 8'hff);
		ctl.issue(EESR_WRITE_COMPLETION_MASK_CMD, 8'h00);
		ctl.issue(EESR_WRITE_FAULT_MASK_CMD, 8'h00);
		query(EESR_READ_COMPLETION_MASK_QUERY, 8'h00);
		query(EESR_READ_FAULT_MASK_QUERY, 8'h00);
		ctl.issue(EESR_SWEEP_MEASURE_CMD, 8'h00);
		chk("measure_active", 8'h01, {7'h0, meas_act});
		ctl.issue(EESR_SINGLE_MEASURE_CMD, 8'h00);
		chk("refused", 8'h01, {7'h0, refused});
		pulse(7'h02);
		chk("measure_active", 8'h00, {7'h0, meas_act});
		query(EESR_READ_COMPLETION_EVENTS_QUERY, 8'h01);
		ctl.issue(EESR_OPC_QUERY, 8'h00);
		busy = 1'b1;
		repeat (4) begin
			@(negedge clock_i) chk("resp_valid", 8'h00, {7'h0, resp_valid});
			chk("cmd_ready", 8'h00, {7'h0, cmd_ready});
		end
		busy = 1'b0;
		for (int i = 0; i < 8 && resp_valid !== 1'b1; i++) @(negedge clock_i);
		chk("opc resp_valid", 8'h01, {7'h0, resp_valid});
		chk("opc answer", EESR_OPC_ANSWER, resp_data);
		ctl.issue(EESR_OPC_CMD, 8'h00);
		chk("opc_set", 8'h01, {7'h0, opc_set});
		do_reset(1'b1);
		query(EESR_READ_COMPLETION_MASK_QUERY, 8'h00);
		query(EESR_READ_FAULT_MASK_QUERY, 8'h00);
		final_report();
	end
endmodule : testbench
